/* File: core/lcs_pkg.sv */
// constants, field layouts and carrier types of the long logic / compare / subtract unit
// assumes an APB4 register bus with 32-bit data and one aligned word per register
package lcs_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_SRC_A_LO = 8'h00;
	localparam logic [7:0] OFS_SRC_A_HI = 8'h04;
	localparam logic [7:0] OFS_SRC_B_LO = 8'h08;
	localparam logic [7:0] OFS_SRC_B_HI = 8'h0C;
	localparam logic [7:0] OFS_DST_LO   = 8'h10;
	localparam logic [7:0] OFS_DST_HI   = 8'h14;
	localparam logic [7:0] OFS_PREFIX   = 8'h18;
	localparam logic [7:0] OFS_INSTR    = 8'h1C;
	localparam logic [7:0] OFS_STATUS   = 8'h20;

	// status word fields
	localparam int STAT_CARRY   = 0;
	localparam int STAT_ILLEGAL = 1;
	localparam int STAT_NOPFX   = 2;
	localparam int STAT_CNT_LO  = 4;
	localparam int STAT_CNT_HI  = 5;

	// reset values
	localparam logic [63:0] RST_WORD64 = 64'h0000_0000_0000_0000;
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;

	// instruction fields (bit 0 of the encoding is the msb of the word)
	localparam int LIT_W       = 16;
	localparam int PFX_W       = 24;
	localparam int OPC_HI      = 31;
	localparam int OPC_LO      = 26;
	localparam int FUNC_HI     = 10;
	localparam int RA_HI       = 20;
	localparam int RA_LO       = 16;
	localparam int BIT_KEEP    = 28;
	localparam int BIT_CIN     = 27;
	localparam int BIT_KEEP_2  = 18;
	localparam int BIT_CIN_2   = 17;

	// opcodes and function fields
	localparam logic [5:0]  OPC_ORL_FIND = 6'h20;
	localparam logic [5:0]  OPC_PCMP_EQ  = 6'h22;
	localparam logic [5:0]  OPC_PCMP_NE  = 6'h23;
	localparam logic [5:0]  OPC_ORLI     = 6'h28;
	localparam logic [5:0]  OPC_LIT_2OP  = 6'h1A;
	localparam logic [5:0]  OPC_SUB_MASK = 6'h39;
	localparam logic [5:0]  OPC_RSUB_REG = 6'h01;
	localparam logic [5:0]  OPC_RSUB_LIT = 6'h09;
	localparam logic [10:0] FUNC_LONG    = 11'h100;
	localparam logic [10:0] FUNC_PCMP    = 11'h500;
	localparam logic [4:0]  RA_OR_2OP    = 5'h10;

	// prefix requests into the literal builder
	typedef struct packed {
		logic             push;
		logic             consume;
		logic [PFX_W-1:0] value;
	} lcs_pfx_req_t;

	// outcome of one executed instruction
	typedef struct packed {
		logic        wr;
		logic        carry_wr;
		logic        carry;
		logic        illegal;
		logic        no_prefix;
		logic [63:0] value;
	} lcs_result_t;

endpackage : lcs_pkg

/* File: core/lcs_prefix.sv */
// prefix holder: keeps up to two 24-bit prefixes and builds the 64-bit literal
// assumes push and consume are single-cycle pulses from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module lcs_prefix
	import lcs_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// requests
	input  wire lcs_pfx_req_t     req_i,
	input  wire logic [LIT_W-1:0] imm_i,
	// literal
	output logic      [1:0]       count_o,
	output logic      [63:0]      literal_o
);

	logic [PFX_W-1:0] pfx_old;
	logic [PFX_W-1:0] pfx_new;
	logic [1:0]       count;
	logic [PFX_W-1:0] next_pfx_old;
	logic [PFX_W-1:0] next_pfx_new;
	logic [1:0]       next_count;
	logic [39:0]      lit40;

	// a push shifts the older prefix up; any executed instruction unlocks them
	always_comb begin
		next_pfx_old = pfx_old;
		next_pfx_new = pfx_new;
		next_count   = count;
		if (req_i.push) begin
			next_pfx_old = pfx_new;
			next_pfx_new = req_i.value;
			next_count   = (count == 2'h2) ? 2'h2 : 2'(count + 2'h1);
		end else if (req_i.consume) begin
			next_count = 2'h0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pfx_old <= 24'h00_0000;
			pfx_new <= 24'h00_0000;
			count   <= 2'h0;
		end else begin
			pfx_old <= next_pfx_old;
			pfx_new <= next_pfx_new;
			count   <= next_count;
		end
	end

	// prefixes form the upper bits, the own 16-bit field the lower bits
	assign lit40 = {pfx_new, imm_i};
	always_comb begin
		unique case (count)
			2'h0:    literal_o = {{48{imm_i[LIT_W-1]}}, imm_i};
			2'h1:    literal_o = {{24{lit40[39]}}, lit40};
			default: literal_o = {pfx_old, pfx_new, imm_i};
		endcase
	end
	assign count_o = count;

	chk_two_prefixes: assert property (@(posedge clk_i) disable iff (reset_i)
		req_i.push && (count != 2'h0) |=> count == 2'h2)
		else $error("two prefixes not both held");

endmodule : lcs_prefix
`default_nettype wire

/* File: core/lcs_unit.sv */
// long logic, pattern compare and reverse subtract execution unit with APB4 register access
// assumes a single clock domain and an APB master on the same clock
//
// Function
// - the register or-long writes first_source OR second_source into dest_register.
// - the literal or-long ORs the extended literal with first_source (three operands) or dest_register (two).
// - the byte find writes the 1-based position of the first equal byte from the msb, or 0 if none.
// - the equality compare writes 1 when both sources are equal and 0 otherwise.
// - the inequality compare writes 0 when both sources are equal and 1 otherwise.
// - the three pattern compares exist only when pattern_compare_option is 1.
// - the reverse subtract writes second_source minus first_source and may update the carry.
// - instruction bit 3 set keeps the carry; cleared lets the subtraction update it.
// - instruction bit 4 set feeds the carry into the subtraction; cleared gives a plain subtraction.
// - the subtraction carry means no borrow when set and a borrow when cleared.
// - the literal reverse subtract writes the extended literal minus the source operand.
// - literal subtraction takes keep from bit 3 or 13 and carry-in from bit 4 or 14 by encoding form.
// - the literal joins each preceding 24-bit prefix above the own 16-bit field, 40 or 64 bits.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lcs_unit
	import lcs_pkg::*;
#(
	parameter int          ADDR_W       = 8,
	parameter logic [0:0]  PCMP_OPTION  = 1'h1
) (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RESET_I,
	// apb slave
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	input  wire logic [3:0]        PSTRB_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O
);

	logic [63:0]  src_a;
	logic [63:0]  src_b;
	logic [63:0]  dst;
	logic         carry;
	logic         illegal;
	logic         no_prefix;
	logic [31:0]  instr;
	logic [31:0]  prdata;
	logic [63:0]  next_src_a;
	logic [63:0]  next_src_b;
	logic [63:0]  next_dst;
	logic         next_carry;
	logic         next_illegal;
	logic         next_no_prefix;
	logic [31:0]  next_instr;
	logic [31:0]  next_prdata;
	logic [7:0]   ofs;
	logic         mapped;
	logic         wr_acc;
	logic         exec;
	logic [31:0]  wmask;
	logic [31:0]  status;
	logic [1:0]   pfx_count;
	logic [63:0]  literal;
	lcs_pfx_req_t pfx_req;
	lcs_result_t  res;
	logic [5:0]   opc;
	logic [10:0]  func;
	logic [7:0]   byte_eq;
	logic         is_orl;
	logic         is_find;
	logic         is_eq;
	logic         is_ne;
	logic         is_orli3;
	logic         is_orli2;
	logic         is_rsub;
	logic         is_rsubli3;
	logic         is_rsubli2;
	logic         sub_keep;
	logic         sub_cin;
	logic [63:0]  sub_min;
	logic [63:0]  sub_sub;
	logic [64:0]  sub_sum;

	// bus decode: zero wait states, unmapped offsets answer with an error
	assign ofs       = 8'(PADDR_I);
	assign mapped    = (ofs <= OFS_STATUS) && (ofs[1:0] == 2'h0);
	assign PREADY_O  = 1'h1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
	assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I && mapped;
	assign exec      = wr_acc && (ofs == OFS_INSTR);
	assign PRDATA_O  = prdata;

	generate
		for (genvar i = 0; i < 4; i++) begin : g_strb
			assign wmask[8*i +: 8] = {8{PSTRB_I[i]}};
		end
	endgenerate

	assign status = {26'h000_0000, pfx_count, 1'h0, no_prefix, illegal, carry};

	// instruction under execution is the word being written
	assign opc  = PWDATA_I[OPC_HI:OPC_LO];
	assign func = PWDATA_I[FUNC_HI:0];

	assign is_orl     = (opc == OPC_ORL_FIND) && (func == FUNC_LONG);
	assign is_find    = (opc == OPC_ORL_FIND) && (func == FUNC_PCMP);
	assign is_eq      = (opc == OPC_PCMP_EQ) && (func == FUNC_PCMP);
	assign is_ne      = (opc == OPC_PCMP_NE) && (func == FUNC_PCMP);
	assign is_orli3   = (opc == OPC_ORLI);
	assign is_orli2   = (opc == OPC_LIT_2OP) && (PWDATA_I[RA_HI:RA_LO] == RA_OR_2OP);
	assign is_rsub    = ((opc & OPC_SUB_MASK) == OPC_RSUB_REG) && (func == FUNC_LONG);
	assign is_rsubli3 = ((opc & OPC_SUB_MASK) == OPC_RSUB_LIT);
	assign is_rsubli2 = (opc == OPC_LIT_2OP) && (PWDATA_I[RA_HI:RA_HI-1] == 2'h0) && PWDATA_I[RA_LO];

	// keep and carry-in come from bits 3/4, or 13/14 in the two-operand form
	assign sub_keep = is_rsubli2 ? PWDATA_I[BIT_KEEP_2] : PWDATA_I[BIT_KEEP];
	assign sub_cin  = is_rsubli2 ? PWDATA_I[BIT_CIN_2] : PWDATA_I[BIT_CIN];

	generate
		for (genvar i = 0; i < 8; i++) begin : g_byte
			assign byte_eq[i] = (src_a[8*i +: 8] == src_b[8*i +: 8]);
		end
	endgenerate

	// minuend minus subtrahend as minuend + ~subtrahend + carry-in
	always_comb begin
		sub_min = src_b;
		sub_sub = src_a;
		if (is_rsubli3) begin
			sub_min = literal;
		end else if (is_rsubli2) begin
			sub_min = literal;
			sub_sub = dst;
		end
		sub_sum = {1'h0, sub_min} + {1'h0, ~sub_sub} + 65'(sub_cin ? carry : 1'h1);
	end

	always_comb begin
		res = '0;
		if (is_orl) begin
			res.wr    = 1'h1;
			res.value = src_a | src_b;
		end else if (is_orli3 || is_orli2) begin
			res.wr        = 1'h1;
			res.value     = (is_orli3 ? src_a : dst) | literal;
			res.no_prefix = is_orli3 && (pfx_count == 2'h0);
		end else if (is_find || is_eq || is_ne) begin
			if (PCMP_OPTION == 1'h1) begin
				res.wr = 1'h1;
				if (is_find) begin
					for (int k = 0; k < 8; k++) begin
						if (byte_eq[k]) begin
							res.value = 64'(8 - k);
						end
					end
				end else begin
					res.value = 64'((src_a == src_b) == is_eq);
				end
			end else begin
				res.illegal = 1'h1;
			end
		end else if (is_rsub || is_rsubli3 || is_rsubli2) begin
			res.wr        = 1'h1;
			res.value     = sub_sum[63:0];
			res.carry_wr  = !sub_keep;
			res.carry     = sub_sum[64];
			res.no_prefix = is_rsubli3 && (pfx_count == 2'h0);
		end else begin
			res.illegal = 1'h1;
		end
	end

	// every executed word unlocks the prefixes
	assign pfx_req.push    = wr_acc && (ofs == OFS_PREFIX);
	assign pfx_req.consume = exec;
	assign pfx_req.value   = PWDATA_I[PFX_W-1:0];

	lcs_prefix u_prefix (
		.clk_i     (CLK_I),
		.reset_i   (RESET_I),
		.req_i     (pfx_req),
		.imm_i     (PWDATA_I[LIT_W-1:0]),
		.count_o   (pfx_count),
		.literal_o (literal)
	);

	// register writes and execution in the access cycle, read capture in the setup cycle
	always_comb begin
		next_src_a     = src_a;
		next_src_b     = src_b;
		next_dst       = dst;
		next_carry     = carry;
		next_illegal   = illegal;
		next_no_prefix = no_prefix;
		next_instr     = instr;
		next_prdata    = prdata;
		if (wr_acc) begin
			unique case (ofs)
				OFS_SRC_A_LO: next_src_a[31:0]  = (src_a[31:0] & ~wmask) | (PWDATA_I & wmask);
				OFS_SRC_A_HI: next_src_a[63:32] = (src_a[63:32] & ~wmask) | (PWDATA_I & wmask);
				OFS_SRC_B_LO: next_src_b[31:0]  = (src_b[31:0] & ~wmask) | (PWDATA_I & wmask);
				OFS_SRC_B_HI: next_src_b[63:32] = (src_b[63:32] & ~wmask) | (PWDATA_I & wmask);
				OFS_DST_LO:   next_dst[31:0]    = (dst[31:0] & ~wmask) | (PWDATA_I & wmask);
				OFS_DST_HI:   next_dst[63:32]   = (dst[63:32] & ~wmask) | (PWDATA_I & wmask);
				OFS_STATUS: begin
					if (PSTRB_I[0]) begin
						next_carry     = PWDATA_I[STAT_CARRY];
						next_illegal   = illegal & ~PWDATA_I[STAT_ILLEGAL];
						next_no_prefix = no_prefix & ~PWDATA_I[STAT_NOPFX];
					end
				end
				OFS_INSTR: begin
					next_instr = PWDATA_I;
					if (res.wr) begin
						next_dst = res.value;
					end
					if (res.carry_wr) begin
						next_carry = res.carry;
					end
					next_illegal   = illegal | res.illegal;
					next_no_prefix = no_prefix | res.no_prefix;
				end
				default: begin
				end
			endcase
		end
		if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			unique case (ofs)
				OFS_SRC_A_LO: next_prdata = src_a[31:0];
				OFS_SRC_A_HI: next_prdata = src_a[63:32];
				OFS_SRC_B_LO: next_prdata = src_b[31:0];
				OFS_SRC_B_HI: next_prdata = src_b[63:32];
				OFS_DST_LO:   next_prdata = dst[31:0];
				OFS_DST_HI:   next_prdata = dst[63:32];
				OFS_INSTR:    next_prdata = instr;
				OFS_STATUS:   next_prdata = status;
				default:      next_prdata = RST_WORD32;
			endcase
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			src_a     <= RST_WORD64;
			src_b     <= RST_WORD64;
			dst       <= RST_WORD64;
			carry     <= 1'h0;
			illegal   <= 1'h0;
			no_prefix <= 1'h0;
			instr     <= RST_WORD32;
			prdata    <= RST_WORD32;
		end else begin
			src_a     <= next_src_a;
			src_b     <= next_src_b;
			dst       <= next_dst;
			carry     <= next_carry;
			illegal   <= next_illegal;
			no_prefix <= next_no_prefix;
			instr     <= next_instr;
			prdata    <= next_prdata;
		end
	end

	chk_or_register: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_orl |=> dst == ($past(src_a) | $past(src_b)))
		else $error("register or result wrong");

	chk_or_literal: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_orli2 |=> dst == ($past(dst) | $past(literal)))
		else $error("literal or result wrong");

	chk_byte_none: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_find && PCMP_OPTION |=> (dst == 64'h0) == ($past(byte_eq) == 8'h00) && dst <= 64'h8)
		else $error("byte find position wrong");

	chk_eq_result: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_eq && PCMP_OPTION |=> dst == 64'($past(src_a) == $past(src_b)))
		else $error("equality compare wrong");

	chk_ne_result: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_ne && PCMP_OPTION |=> dst == 64'($past(src_a) != $past(src_b)))
		else $error("inequality compare wrong");

	chk_pcmp_gated: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && (is_find || is_eq || is_ne) && !PCMP_OPTION |=> $stable(dst) && illegal)
		else $error("pattern compare ran while disabled");

	chk_sub_value: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_rsub && !sub_cin |=> dst == 64'($past(src_b) - $past(src_a)))
		else $error("reverse subtract value wrong");

	chk_keep_carry: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && (is_rsub || is_rsubli3 || is_rsubli2) && sub_keep |=> $stable(carry))
		else $error("kept carry changed");

	chk_carry_in: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_rsub && sub_cin && !carry |=> dst == 64'($past(src_b) - $past(src_a) - 64'h1))
		else $error("carry-in not applied");

	chk_carry_borrow: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_rsub && !sub_keep && !sub_cin |=> carry == ($past(src_b) >= $past(src_a)))
		else $error("carry is not inverse borrow");

	chk_lit_sub: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_rsubli2 && !sub_cin |=> dst == 64'($past(literal) - $past(dst)))
		else $error("literal subtract value wrong");

	chk_lit_keep_bit: assert property (@(posedge CLK_I) disable iff (RESET_I)
		exec && is_rsubli2 && PWDATA_I[BIT_KEEP_2] |=> $stable(carry))
		else $error("two-operand keep bit ignored");

endmodule : lcs_unit
`default_nettype wire

/* File: sim/test_lcs_unit.sv */
// self-checking bench of the long logic / compare / subtract unit, all traffic over its apb port
// assumes the unit answers apb within a few cycles and runs on one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_lcs_unit
	import lcs_pkg::*;
;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] prdata_n;
	logic [3:0]  pstrb;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	logic [63:0] a;
	logic [63:0] b;
	logic [63:0] dst;
	logic [63:0] dst_n;
	logic [31:0] rd_n;
	logic [64:0] res;
	int          failures;
	int          checks;

	lcs_unit #(.ADDR_W(8), .PCMP_OPTION(1'h1)) u_dut (
		.CLK_I    (clk),
		.RESET_I  (rst),
		.PSEL_I   (psel),
		.PENABLE_I(pen),
		.PWRITE_I (pwr),
		.PADDR_I  (paddr),
		.PWDATA_I (pwdata),
		.PSTRB_I  (pstrb),
		.PRDATA_O (prdata),
		.PREADY_O (pready),
		.PSLVERR_O(pslverr)
	);

	// same traffic into a unit built without the pattern compares
	lcs_unit #(.ADDR_W(8), .PCMP_OPTION(1'h0)) u_dut_nopcmp (
		.CLK_I    (clk),
		.RESET_I  (rst),
		.PSEL_I   (psel),
		.PENABLE_I(pen),
		.PWRITE_I (pwr),
		.PADDR_I  (paddr),
		.PWDATA_I (pwdata),
		.PSTRB_I  (pstrb),
		.PRDATA_O (prdata_n),
		.PREADY_O (),
		.PSLVERR_O()
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		rd_n = prdata_n;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 50) begin
			failures++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
		end
	endtask : apb

	task automatic set64(input logic [7:0] ofs, input logic [63:0] v);
		apb(1'b1, ofs, v[31:0]);
		apb(1'b1, 8'(ofs + 8'h04), v[63:32]);
	endtask : set64

	// execute one instruction word and read back the destination
	task automatic exe(input logic [63:0] sa, input logic [63:0] sb, input logic [31:0] ins);
		set64(OFS_SRC_A_LO, sa);
		set64(OFS_SRC_B_LO, sb);
		apb(1'b1, OFS_INSTR, ins);
		apb(1'b0, OFS_DST_LO, 32'h0000_0000);
		dst[31:0] = rd;
		dst_n[31:0] = rd_n;
		apb(1'b0, OFS_DST_HI, 32'h0000_0000);
		dst[63:32] = rd;
		dst_n[63:32] = rd_n;
	endtask : exe

	function automatic logic [64:0] rsub(input logic [63:0] m, input logic [63:0] s, input logic cin);
		return {1'b0, m} + {1'b0, ~s} + 65'(cin);
	endfunction : rsub

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("CHECK FAILED watchdog expected done seen running");
		conclude();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		failures = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status reset", 64'(RST_WORD32), 64'(rd));
		// register or
		a = 64'hF0F0_0000_1234_5678;
		b = 64'h0F00_00FF_0000_8001;
		exe(a, b, {OPC_ORL_FIND, 15'h0000, FUNC_LONG});
		chk("or_long", a | b, dst);
		$display("or register test done");
		// byte find, every position and the no-match case
		a = 64'h0011_2233_4455_6677;
		for (int k = 0; k <= 8; k++) begin
			b = ~a;
			if (k > 0) begin
				b[71-8*k -: 8] = a[71-8*k -: 8];
				b[7:0] = a[7:0];
			end
			exe(a, b, {OPC_ORL_FIND, 15'h0000, FUNC_PCMP});
			chk("byte_find", 64'(k), dst);
		end
		// equality and inequality
		for (int e = 0; e <= 1; e++) begin
			b = (e == 1) ? a : a ^ 64'h0000_0000_0000_0001;
			exe(a, b, {OPC_PCMP_EQ, 15'h0000, FUNC_PCMP});
			chk("equal", 64'(e), dst);
			exe(a, b, {OPC_PCMP_NE, 15'h0000, FUNC_PCMP});
			chk("not_equal", 64'(1 - e), dst);
		end
		$display("pattern compare test done");
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("pcmp on flag", 64'h0, 64'(rd[STAT_ILLEGAL]));
		chk("pcmp off flag", 64'h1, 64'(rd_n[STAT_ILLEGAL]));
		chk("pcmp off dst", 64'hFFF0_00FF_1234_D679, dst_n);
		// register reverse subtract: keep, carry-in and starting carry
		a = 64'h8000_0000_0000_0001;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_STATUS, 32'(i[0]));
			res = rsub(a, a, i[1] ? i[0] : 1'b1);
			exe(a, a, {3'b000, i[2], i[1], 1'b1, 15'h0000, FUNC_LONG});
			chk("rsub", res[63:0], dst);
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			chk("rsub carry", 64'(i[2] ? i[0] : res[64]), 64'(rd));
		end
		b = 64'h0000_0000_0000_0005;
		exe(64'h0000_0000_0000_0007, b, {OPC_RSUB_REG, 15'h0000, FUNC_LONG});
		chk("rsub borrow", 64'hFFFF_FFFF_FFFF_FFFE, dst);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("borrow carry", 64'h0, 64'(rd));
		$display("register subtract test done");
		// literal or, two prefixes, one prefix, none
		apb(1'b1, OFS_PREFIX, 32'h00AB_CDEF);
		apb(1'b1, OFS_PREFIX, 32'h0012_3456);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("prefix count", 64'h2, 64'(rd[STAT_CNT_HI:STAT_CNT_LO]));
		exe(64'h1, b, {OPC_ORLI, 10'h000, 16'h8001});
		chk("orli 64", 64'hABCD_EF12_3456_8001, dst);
		set64(OFS_DST_LO, 64'h0000_0000_0000_0101);
		apb(1'b1, OFS_PREFIX, 32'h0080_0000);
		exe(a, b, {OPC_LIT_2OP, 5'h00, RA_OR_2OP, 16'h0002});
		chk("orli 40", 64'hFFFF_FF80_0000_0103, dst);
		exe(a, b, {OPC_LIT_2OP, 5'h00, RA_OR_2OP, 16'h8000});
		chk("orli 16", 64'hFFFF_FFFF_FFFF_8103, dst);
		$display("literal or test done");
		// literal reverse subtract, both encodings, keep and carry-in
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_STATUS, 32'h0000_0000);
			if (i[2]) begin
				set64(OFS_DST_LO, 64'h0000_0000_0001_0000);
			end
			apb(1'b1, OFS_PREFIX, 32'h0000_0001);
			res = rsub(64'h0000_0000_0001_0000, 64'h0000_0000_0001_0000, i[0] ? 1'b0 : 1'b1);
			if (i[2]) begin
				exe(a, b, {OPC_LIT_2OP, 5'h00, 2'b00, i[1], i[0], 1'b1, 16'h0000});
			end else begin
				exe(64'h0000_0000_0001_0000, b, {3'b001, i[1], i[0], 1'b1, 10'h000, 16'h0000});
			end
			chk("rsubli", res[63:0], dst);
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			chk("rsubli carry", 64'(i[1] ? 1'b0 : res[64]), 64'(rd[STAT_CARRY]));
		end
		$display("literal subtract test done");
		// three-operand literal with no prefix still runs and is flagged
		exe(64'h0, b, {OPC_ORLI, 10'h000, 16'h0001});
		chk("no prefix result", 64'h1, dst);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("no prefix flag", 64'h1, 64'(rd[STAT_NOPFX]));
		apb(1'b1, OFS_STATUS, 32'h0000_0004);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("no prefix clear", 64'h0, 64'(rd[STAT_NOPFX]));
		exe(64'h1, b, {3'b001, 1'b0, 1'b0, 1'b1, 10'h000, 16'h0005});
		chk("rsubli no prefix", 64'h4, dst);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("rsubli no prefix flag", 64'h1, 64'(rd[STAT_NOPFX]));
		// undefined opcode leaves the destination alone
		exe(a, b, 32'hFC00_0000);
		chk("illegal dst", 64'h4, dst);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("illegal flag", 64'h1, 64'(rd[STAT_ILLEGAL]));
		apb(1'b0, OFS_INSTR, 32'h0000_0000);
		chk("instr readback", 64'hFC00_0000, 64'(rd));
		apb(1'b0, OFS_PREFIX, 32'h0000_0000);
		chk("prefix reads zero", 64'h0, 64'(rd));
		// unmapped address
		apb(1'b1, 8'h24, 32'hFFFF_FFFF);
		chk("unmapped write err", 64'h1, 64'(err));
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk("unmapped read err", 64'h1, 64'(err));
		chk("unmapped read data", 64'h0, 64'(rd));
		// byte strobes mask destination writes
		set64(OFS_DST_LO, 64'h0000_0000_0000_0000);
		pstrb <= 4'h2;
		apb(1'b1, OFS_DST_LO, 32'hFFFF_FFFF);
		pstrb <= 4'hF;
		apb(1'b0, OFS_DST_LO, 32'h0000_0000);
		chk("strobe write", 64'h0000_FF00, 64'(rd));
		$display("error handling test done");
		conclude();
	end
endmodule : test_lcs_unit
`default_nettype wire
